// ### hdl/b2_sram_port.v
// burst-of-two dual-port-rate sram port, sampled on the system clock
//
// Contract
// - array depth per organisation, 36/18/9 bits
// - write on both k edges, read both c
// - inputs sampled against k or k_n
// - c pair both high: outputs timed by k
// - echo clock pair follows read data
// - read address at k, write at k_n
// - fixed two-bit sequential burst counter
// - mask low enables all nine bits
// - read select low at k starts read
// - each read returns exactly two words
// - word0 at c_n after k_n, word1 at c
// - back-to-back reads give gapless data
// - read deselect finishes burst then high-z
// - dll disable pin low disables loop
// - read and write selects active low
// - write word0 at k, word1 at k_n
// - burst address linear, second is plus one
// - read and write paths run concurrently
// - write data ignored while write deselected
`timescale 1ns/100ps
`include "burst2_sram_consts.vh"
module b2_sram_port #(
    parameter DATA_W = `DATA_W_DEF,
    parameter ADDR_W = `ADDR_W_DEF
) (
    // system
    input  wire              CLK_SYS_IN,
    input  wire              SYS_RST_IN,
    // input clock pair
    input  wire              K_CLK_IN,
    input  wire              K_CLK_N_IN,
    // output clock pair
    input  wire              C_CLK_IN,
    input  wire              C_CLK_N_IN,
    // commands and address
    input  wire              READ_SEL_N_IN,
    input  wire              WRITE_SEL_N_IN,
    input  wire [ADDR_W-1:0] SHARED_ADDRESS_BUS_IN,
    // write port
    input  wire [DATA_W-1:0] WRITE_DATA_IN,
    input  wire              BYTE_WRITE_MASK_N_IN,
    // dll control
    input  wire              DLL_OFF_N_IN,
    output wire              DLL_ENABLED_OUT,
    // read port
    output reg  [DATA_W-1:0] READ_DATA_OUT,
    output reg               READ_DATA_OE_OUT,
    output reg               ECHO_CLOCK_PAIR_OUT,
    output reg               ECHO_CLOCK_PAIR_N_OUT
);
    localparam SW = 5 + ADDR_W + DATA_W + 1;
    localparam [1:0] RD_IDLE  = `RD_IDLE;
    localparam [1:0] RD_WORD0 = `RD_WORD0;
    localparam [1:0] RD_WORD1 = `RD_WORD1;

    // every pin except SYS_RST_IN and DLL_OFF_N_IN passes two flops; edges come from the second stage
    wire [SW-1:0] raw_in;
    wire [SW-1:0] syn;
    wire [SW-1:0] rise;
    assign raw_in = {K_CLK_IN, K_CLK_N_IN, C_CLK_IN, C_CLK_N_IN,
                     READ_SEL_N_IN, SHARED_ADDRESS_BUS_IN,
                     WRITE_DATA_IN, BYTE_WRITE_MASK_N_IN};
    b2_sync2 #(.W(SW)) u_sync (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (SYS_RST_IN),
        .d_in     (raw_in),
        .q_out    (syn),
        .rise_out (rise)
    );
    wire              k_rise    = rise[SW-1];
    wire              kn_rise   = rise[SW-2];
    wire              c_s       = syn[SW-3];
    wire              cn_s      = syn[SW-4];
    wire              c_rise    = rise[SW-3];
    wire              cn_rise   = rise[SW-4];
    wire              rsel_n    = syn[SW-5];
    wire [ADDR_W-1:0] addr_s    = syn[ADDR_W+DATA_W:DATA_W+1];
    wire [DATA_W-1:0] wdata_s   = syn[DATA_W:1];
    wire              mask_n_s  = syn[0];
    // write select synchronised separately to keep port names tidy
    reg               ws1_r;
    reg               wsel_n;
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            ws1_r  <= 1'b1;
            wsel_n <= 1'b1;
        end else begin
            ws1_r  <= WRITE_SEL_N_IN;
            wsel_n <= ws1_r;
        end
    end

    assign DLL_ENABLED_OUT = DLL_OFF_N_IN;

    // single clock mode latched once after reset release
    reg single_clk_r;
    reg mode_done_r;
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            single_clk_r <= 1'b0;
            mode_done_r  <= 1'b0;
        end else if (!mode_done_r && k_rise) begin
            single_clk_r <= c_s & cn_s;
            mode_done_r  <= 1'b1;
        end
    end
    wire out_rise   = single_clk_r ? k_rise  : c_rise;
    wire out_n_rise = single_clk_r ? kn_rise : cn_rise;

    // write path
    reg              wr_pend_r;
    reg [DATA_W-1:0] wd0_r;
    reg              wm0_r;
    reg [ADDR_W-1:0] wa_r;
    reg              mem_we;
    reg [ADDR_W-1:0] mem_wa;
    reg [DATA_W-1:0] mem_wd;
    reg              wr2_r;
    reg [DATA_W-1:0] wd1_r;
    reg              wm1_r;
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            wr_pend_r <= 1'b0;
            wd0_r     <= {DATA_W{1'b0}};
            wm0_r     <= 1'b1;
            wa_r      <= {ADDR_W{1'b0}};
            wr2_r     <= 1'b0;
            wd1_r     <= {DATA_W{1'b0}};
            wm1_r     <= 1'b1;
        end else begin
            wr2_r <= 1'b0;
            if (k_rise) begin
                wr_pend_r <= ~wsel_n;
                wd0_r     <= wdata_s;
                wm0_r     <= mask_n_s;
            end else if (kn_rise && wr_pend_r) begin
                wr_pend_r <= 1'b0;
                wa_r      <= addr_s;
                wd1_r     <= wdata_s;
                wm1_r     <= mask_n_s;
                wr2_r     <= 1'b1;
            end
        end
    end
    // word0 written the cycle the address lands, word1 the next
    reg wr1_go_r;
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            wr1_go_r <= 1'b0;
        end else begin
            wr1_go_r <= wr2_r;
        end
    end
    always @* begin
        mem_we = 1'b0;
        mem_wa = wa_r;
        mem_wd = wd0_r;
        if (wr2_r) begin
            mem_we = ~wm0_r;
            mem_wa = {wa_r[ADDR_W-1:1], 1'b0};
            mem_wd = wd0_r;
        end else if (wr1_go_r) begin
            mem_we = ~wm1_r;
            mem_wa = {wa_r[ADDR_W-1:1], 1'b1};
            mem_wd = wd1_r;
        end
    end

    // read path runs alongside the write path
    reg [1:0]        rd_st_r;
    reg [1:0]        rd_st_nxt;
    reg              rd_cmd_r;
    reg [ADDR_W-1:0] ra_r;
    reg              rd_ready_r;
    reg              mem_re;
    reg              mem_ra_lsb;
    wire [DATA_W-1:0] mem_rd;
    reg [DATA_W-1:0] rw0_r;
    reg [DATA_W-1:0] rw1_r;
    reg              pend_r;
    // pair held until its output edge; a next read refetches earlier
    reg [DATA_W-1:0] bw0_r;
    reg [DATA_W-1:0] bw1_r;
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            rd_cmd_r <= 1'b0;
            ra_r     <= {ADDR_W{1'b0}};
            pend_r   <= 1'b0;
            bw0_r    <= {DATA_W{1'b0}};
            bw1_r    <= {DATA_W{1'b0}};
        end else if (k_rise) begin
            rd_cmd_r <= ~rsel_n;
            if (!rsel_n) begin
                ra_r <= addr_s;
            end
        end else if (kn_rise) begin
            pend_r   <= rd_cmd_r;
            rd_cmd_r <= 1'b0;
            if (rd_cmd_r) begin
                bw0_r <= rw0_r;
                bw1_r <= rw1_r;
            end
        end
    end

    // fetch both burst words right after the command is taken
    reg [1:0] fetch_r;
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            fetch_r <= 2'h0;
        end else if (k_rise && !rsel_n) begin
            fetch_r <= 2'h1;
        end else if (fetch_r != 2'h0) begin
            fetch_r <= (fetch_r == 2'h3) ? 2'h0 : fetch_r + 2'h1;
        end
    end
    always @* begin
        mem_re     = (fetch_r == 2'h1) || (fetch_r == 2'h2);
        mem_ra_lsb = (fetch_r == 2'h2);
    end
    // both words are in hand before the k_n edge that holds them
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            rw0_r <= {DATA_W{1'b0}};
            rw1_r <= {DATA_W{1'b0}};
        end else if (fetch_r == 2'h2) begin
            rw0_r <= mem_rd;
        end else if (rd_ready_r) begin
            rw1_r <= mem_rd;
        end
    end
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            rd_ready_r <= 1'b0;
        end else begin
            rd_ready_r <= (fetch_r == 2'h2);
        end
    end

    b2_sram_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mem (
        .clk_in    (CLK_SYS_IN),
        .we_in     (mem_we),
        .waddr_in  (mem_wa),
        .wdata_in  (mem_wd),
        .re_in     (mem_re),
        .raddr_in  ({ra_r[ADDR_W-1:1], mem_ra_lsb}),
        .rdata_out (mem_rd)
    );

    // output sequencer: word0 on out_n edge, word1 on next out edge
    reg [DATA_W-1:0] hold1_r;
    always @* begin
        rd_st_nxt = rd_st_r;
        case (rd_st_r)
            RD_IDLE: begin
                if (out_n_rise && pend_r) begin
                    rd_st_nxt = RD_WORD0;
                end
            end
            RD_WORD0: begin
                if (out_rise) begin
                    rd_st_nxt = RD_WORD1;
                end
            end
            RD_WORD1: begin
                if (out_n_rise) begin
                    rd_st_nxt = pend_r ? RD_WORD0 : RD_IDLE;
                end
            end
            default: begin
                rd_st_nxt = RD_IDLE;
            end
        endcase
    end
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            rd_st_r          <= RD_IDLE;
            READ_DATA_OUT    <= {DATA_W{1'b0}};
            READ_DATA_OE_OUT <= 1'b0;
            hold1_r          <= {DATA_W{1'b0}};
        end else begin
            rd_st_r <= rd_st_nxt;
            if (rd_st_nxt == RD_WORD0 && rd_st_r != RD_WORD0) begin
                READ_DATA_OUT    <= bw0_r;
                hold1_r          <= bw1_r;
                READ_DATA_OE_OUT <= 1'b1;
            end else if (rd_st_nxt == RD_WORD1 && rd_st_r == RD_WORD0) begin
                READ_DATA_OUT <= hold1_r;
            end else if (rd_st_nxt == RD_IDLE) begin
                READ_DATA_OE_OUT <= 1'b0;
            end
        end
    end

    // echo clocks toggle with the active output timing edges
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            ECHO_CLOCK_PAIR_OUT   <= 1'b0;
            ECHO_CLOCK_PAIR_N_OUT <= 1'b1;
        end else if (out_rise) begin
            ECHO_CLOCK_PAIR_OUT   <= 1'b1;
            ECHO_CLOCK_PAIR_N_OUT <= 1'b0;
        end else if (out_n_rise) begin
            ECHO_CLOCK_PAIR_OUT   <= 1'b0;
            ECHO_CLOCK_PAIR_N_OUT <= 1'b1;
        end
    end
endmodule // b2_sram_port

// ### shared/burst2_sram_consts.vh
// constants for the burst-of-two sram port
`ifndef BURST2_SRAM_CONSTS_VH
`define BURST2_SRAM_CONSTS_VH
`define DATA_W_DEF        9
`define ADDR_W_DEF        22
`define DEPTH_X36         32'h0010_0000
`define DEPTH_X18         32'h0020_0000
`define DEPTH_X9          32'h0040_0000
`define SYNC_STAGES       2
`define SYNC_WARM         2'h3
`define BURST_LEN         2
`define RD_IDLE           2'h0
`define RD_WORD0          2'h1
`define RD_WORD1          2'h2
`endif

// ### hdl/b2_sync2.v
// two flip-flop synchroniser with edge outputs taken off the second stage
`timescale 1ns/100ps
`include "burst2_sram_consts.vh"
module b2_sync2 #(
    parameter W = 1
) (
    input  wire         clk_in,
    input  wire         rst_in,
    input  wire [W-1:0] d_in,
    output reg  [W-1:0] q_out,
    output wire [W-1:0] rise_out
);
    reg [W-1:0] s1_r;
    reg [W-1:0] q_d_r;
    // no edge until both stages and the delay hold real pin values
    reg [1:0]   warm_r;
    always @(posedge clk_in) begin
        if (rst_in) begin
            s1_r   <= {W{1'b0}};
            q_out  <= {W{1'b0}};
            q_d_r  <= {W{1'b0}};
            warm_r <= 2'h0;
        end else begin
            s1_r  <= d_in;
            q_out <= s1_r;
            q_d_r <= q_out;
            if (warm_r != `SYNC_WARM) begin
                warm_r <= warm_r + 2'h1;
            end
        end
    end
    assign rise_out = q_out & ~q_d_r & {W{warm_r == `SYNC_WARM}};
endmodule // b2_sync2

// ### hdl/b2_sram_mem.v
// word memory with single write enable and registered read data
`timescale 1ns/100ps
module b2_sram_mem #(
    parameter DATA_W = 9,
    parameter ADDR_W = 22
) (
    input  wire              clk_in,
    input  wire              we_in,
    input  wire [ADDR_W-1:0] waddr_in,
    input  wire [DATA_W-1:0] wdata_in,
    input  wire              re_in,
    input  wire [ADDR_W-1:0] raddr_in,
    output reg  [DATA_W-1:0] rdata_out
);
    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    always @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        if (re_in) begin
            rdata_out <= mem[raddr_in];
        end
    end
endmodule // b2_sram_mem

// ### sim/b2_sram_props.sv
// checker for the burst-of-two sram port
`timescale 1ns/100ps
module b2_sram_props #(
    parameter DATA_W = 9,
    parameter ADDR_W = 22
) (
    input wire              CLK_SYS_IN,
    input wire              SYS_RST_IN,
    input wire              READ_SEL_N_IN,
    input wire              DLL_OFF_N_IN,
    input wire              DLL_ENABLED_OUT,
    input wire [DATA_W-1:0] READ_DATA_OUT,
    input wire              READ_DATA_OE_OUT,
    input wire              ECHO_CLOCK_PAIR_OUT,
    input wire              ECHO_CLOCK_PAIR_N_OUT
);
    // cycles since read select was last seen low
    reg [5:0] idle_r;
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN || !READ_SEL_N_IN)
            idle_r <= 6'h00;
        else if (idle_r != 6'h3f)
            idle_r <= idle_r + 6'h01;
    end
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (SYS_RST_IN);
    sequence s_burst; READ_DATA_OE_OUT [*8]; endsequence
    sequence s_half; $stable(ECHO_CLOCK_PAIR_OUT) [*2]; endsequence
    sequence s_next; ##[1:6] $changed(ECHO_CLOCK_PAIR_OUT); endsequence
    property p_dll; DLL_ENABLED_OUT == DLL_OFF_N_IN; endproperty
    property p_pair; ECHO_CLOCK_PAIR_N_OUT == !ECHO_CLOCK_PAIR_OUT;
    endproperty
    property p_hold; $changed(ECHO_CLOCK_PAIR_OUT) |=> s_half; endproperty
    property p_run; $changed(ECHO_CLOCK_PAIR_OUT) |=> s_next; endproperty
    property p_burst; $rose(READ_DATA_OE_OUT) |-> s_burst; endproperty
    property p_word; READ_DATA_OE_OUT && $past(READ_DATA_OE_OUT) &&
        $changed(READ_DATA_OUT) |-> $changed(ECHO_CLOCK_PAIR_OUT);
    endproperty
    property p_first; $rose(READ_DATA_OE_OUT) |->
        $changed(ECHO_CLOCK_PAIR_OUT); endproperty
    property p_desel; idle_r >= 6'h18 |-> !READ_DATA_OE_OUT; endproperty
    property p_cause; $rose(READ_DATA_OE_OUT) |-> idle_r <= 6'h10;
    endproperty
    a_dll: assert property (p_dll) else $error("dll flag off");
    a_pair: assert property (p_pair) else $error("echo pair");
    a_hold: assert property (p_hold) else $error("echo fast");
    a_run: assert property (p_run) else $error("echo stopped");
    a_burst: assert property (p_burst) else $error("short");
    a_word: assert property (p_word) else $error("data edge");
    a_first: assert property (p_first) else $error("word0 edge");
    a_desel: assert property (p_desel) else $error("no high-z");
    a_cause: assert property (p_cause) else $error("stray read");
endmodule // b2_sram_props
bind b2_sram_port b2_sram_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W))
    b2_sram_props_inst (.CLK_SYS_IN, .SYS_RST_IN, .READ_SEL_N_IN,
    .DLL_OFF_N_IN, .DLL_ENABLED_OUT, .READ_DATA_OUT, .READ_DATA_OE_OUT,
    .ECHO_CLOCK_PAIR_OUT, .ECHO_CLOCK_PAIR_N_OUT);

// ### sim/ctrl_clk_model.sv
// controller side clock pairs for the burst-of-two sram port
`timescale 1ns/100ps
module ctrl_clk_model (
    // mode
    input  wire single_in,
    // clock pairs
    output reg  k_out,
    output wire k_n_out,
    output wire c_out,
    output wire c_n_out
);
    reg c_r;
    // phase unrelated to the system clock, 80 ns period
    initial begin
        k_out = 1'b0;
        c_r = 1'b0;
        #3;
        forever #40 k_out = ~k_out;
    end
    // output clock lags the input clock by a quarter period
    always @(k_out) c_r <= #20 k_out;
    assign k_n_out = ~k_out;
    assign c_out = single_in | c_r;
    assign c_n_out = single_in | ~c_r;
endmodule // ctrl_clk_model

// ### sim/testbench.sv
// self-checking bench for the burst-of-two sram port
`timescale 1ns/100ps
module testbench;
    reg         clk, rst, single, rsel_n, wsel_n, mask_n, dll_n, echo_d;
    reg  [21:0] addr;
    reg  [8:0]  wdata;
    reg  [31:0] seed;
    reg  [8:0]  ref_mem [0:15];
    integer     mismatches, tests_run, cyc, i, mode;
    logic [8:0] exp_q [$];
    wire        k, k_n, c, c_n, dll_en, oe, echo, echo_n;
    wire [8:0]  rdata;

    ctrl_clk_model ctrl_clk_model_inst (.single_in(single), .k_out(k),
        .k_n_out(k_n), .c_out(c), .c_n_out(c_n));
    b2_sram_port #(.DATA_W(9), .ADDR_W(22)) b2_sram_port_inst (
        .CLK_SYS_IN(clk), .SYS_RST_IN(rst), .K_CLK_IN(k), .K_CLK_N_IN(k_n),
        .C_CLK_IN(c), .C_CLK_N_IN(c_n), .READ_SEL_N_IN(rsel_n),
        .WRITE_SEL_N_IN(wsel_n), .SHARED_ADDRESS_BUS_IN(addr),
        .WRITE_DATA_IN(wdata), .BYTE_WRITE_MASK_N_IN(mask_n),
        .DLL_OFF_N_IN(dll_n), .DLL_ENABLED_OUT(dll_en),
        .READ_DATA_OUT(rdata), .READ_DATA_OE_OUT(oe),
        .ECHO_CLOCK_PAIR_OUT(echo), .ECHO_CLOCK_PAIR_N_OUT(echo_n));

    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] expect_v);
        begin
            tests_run = tests_run + 1;
            if (seen !== expect_v) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: got %h want %h", $time, seen,
                    expect_v);
            end
        end
    endtask

    task complete_run;
        begin
            if (mismatches == 0 && tests_run > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask

    // one input clock period: command phase at k, write phase at k_n
    task kcyc(input r_n, input w_n, input [3:0] ra, input [3:0] wa,
              input m0, input m1);
        reg [8:0] d0, d1;
        begin
            seed = lfsr(seed);
            d0 = seed[8:0];
            d1 = seed[17:9];
            rsel_n <= r_n;
            wsel_n <= w_n;
            addr <= {18'h0_0000, ra};
            wdata <= d0;
            mask_n <= m0;
            dll_n <= seed[20];
            if (!r_n) begin
                exp_q.push_back(ref_mem[{ra[3:1], 1'b0}]);
                exp_q.push_back(ref_mem[{ra[3:1], 1'b1}]);
            end
            @(posedge k);
            repeat (4) @(negedge clk);
            addr <= {18'h0_0000, wa};
            wdata <= d1;
            mask_n <= m1;
            @(posedge k_n);
            repeat (4) @(negedge clk);
            check(dll_en, dll_n);
            if (!w_n && !m0) ref_mem[{wa[3:1], 1'b0}] = d0;
            if (!w_n && !m1) ref_mem[{wa[3:1], 1'b1}] = d1;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // every output edge with the driver on carries the oldest noted word
    always @(negedge clk) begin
        echo_d <= echo;
        if (!rst && oe === 1'b1 && echo !== echo_d) begin
            check(echo_n, !echo);
            if (exp_q.size() == 0)
                check(32'h0000_0000, 32'h0000_0001);
            else
                check(rdata, exp_q.pop_front());
        end
    end

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end

    initial begin
        {rst, single, rsel_n, wsel_n, mask_n, dll_n} = 6'b1_0111_1;
        {echo_d, addr, wdata} = 32'h0000_0000;
        {mismatches, tests_run, cyc} = 0;
        seed = 32'hb1c9;
        for (mode = 0; mode < 2; mode = mode + 1) begin
            single = mode;
            rst = 1'b1;
            repeat (8) @(negedge clk);
            rst = 1'b0;
            @(posedge k_n);
            repeat (4) @(negedge clk);
            for (i = 0; i < 8; i = i + 1)
                kcyc(1, 0, 0, {i[2:0], seed[0]}, 0, 0);
            kcyc(1, 1, 0, 4'h2, 0, 0);
            kcyc(1, 0, 0, 4'h3, 0, 1);
            for (i = 0; i < 8; i = i + 1)
                kcyc(0, 0, {i[2:0], seed[1]}, {i[2:0] + 3'h4, seed[2]},
                     seed[3] & seed[4], 0);
            kcyc(0, 1, 4'h5, 0, 1, 1);
            for (i = 0; i < 4; i = i + 1)
                kcyc(1, 1, 0, 0, 0, 0);
            check(oe, 0);
        end
        check(exp_q.size(), 0);
        complete_run;
    end
endmodule // testbench
